// ==== hdl/sfcfg_top.sv ====
// Summary of operation
// - 5-bit if word, reset 15, rx subtract
// - signed offset added to base word
// - strobe or auto correction adds estimate
// - base word bits 23:22 read zero
// - high register gives base bits 21:16
// - bandwidth fields set decimation ratio
// - 4-bit rate exponent, reset 1100
// - rate is hidden-one significand shifted
// - channel times spacing added to base
//
// Decided for this implementation: the APB register port.
module sfcfg_top (
  input  wire logic                i_ref_clk,
  input  wire logic                i_srst,
  input  wire logic                i_psel,
  input  wire logic                i_penable,
  input  wire logic                i_pwrite,
  input  wire logic [31:0]         i_paddr,
  input  wire logic [31:0]         i_pwdata,
  input  wire logic [3:0]          i_pstrb,
  input  wire logic [7:0]          i_offset_estimate,
  input  wire logic                i_auto_correct,
  output logic [31:0]              o_prdata,
  output logic                     o_pready,
  output logic                     o_pslverr,
  output sfcfg_pkg::sfcfg_out_t    o_cfg
);
  import sfcfg_pkg::*;

  logic [7:0]  if_q, if_d;
  logic [7:0]  off_q, off_d;
  logic [7:0]  hi_q, hi_d;
  logic [7:0]  mid_q, mid_d;
  logic [7:0]  lo_q, lo_d;
  logic [7:0]  bw_q, bw_d;
  logic [7:0]  channel_index_q, channel_index_d;
  logic [7:0]  spc_q, spc_d;
  logic [7:0]  sig_q, sig_d;
  logic        rx_q, rx_d;
  logic        auto_en_q, auto_en_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;
  sfcfg_out_t  cfg_q, cfg_d;

  logic        auto_rise;
  logic        setup;
  logic        wr;
  logic [15:0] idx;
  logic        hit;
  logic        strobe;
  logic [7:0]  wb;
  logic [23:0] base_word;
  logic [23:0] shift_word;
  logic [23:0] channel_index_word;
  logic [23:0] tuned_word;
  logic [23:0] if_word;
  logic [3:0]  bw_div;

  sfcfg_sync u_auto_sync (
    .i_ref_clk (i_ref_clk),
    .i_srst    (i_srst),
    .i_async   (i_auto_correct),
    .o_level   (),
    .o_rise    (auto_rise)
  );

  // no wait state: answer in the cycle after setup
  assign setup = i_psel & ~i_penable;
  assign wr    = i_psel & i_penable & i_pwrite & pready_q;
  assign idx   = i_paddr[IDX_LSB +: 16];
  assign wb    = i_pstrb[0] ? i_pwdata[7:0] : 8'h00;

  always_comb begin
    case (idx)
      IF_TUNING_CTRL_IDX, SYNTH_OFFSET_CTRL_IDX, SYNTH_BASE_HIGH_IDX,
      SYNTH_BASE_MID_IDX, SYNTH_BASE_LOW_IDX, BANDWIDTH_RATE_CFG_IDX,
      CHANNEL_INDEX_IDX, SPACING_CFG_IDX, SIGNIFICAND_CFG_IDX,
      RADIO_CTRL_IDX, SYNTH_WORD_RD_IDX, RX_WORD_RD_IDX,
      RATE_WORD_RD_IDX, DECIM_RD_IDX: hit = 1'b1;
      default:                        hit = 1'b0;
    endcase
  end

  // register writes; only byte lane 0 carries data
  always_comb begin
    if_d      = if_q;
    off_d     = off_q;
    hi_d      = hi_q;
    mid_d     = mid_q;
    lo_d      = lo_q;
    bw_d      = bw_q;
    channel_index_d    = channel_index_q;
    spc_d     = spc_q;
    sig_d     = sig_q;
    rx_d      = rx_q;
    auto_en_d = auto_en_q;
    strobe    = 1'b0;
    if (wr && i_pstrb[0]) begin
      case (idx)
        IF_TUNING_CTRL_IDX:     if_d = wb & IF_WORD_MASK;
        SYNTH_OFFSET_CTRL_IDX:  off_d = wb;
        SYNTH_BASE_HIGH_IDX:    hi_d = wb & BASE_HIGH_MASK;
        SYNTH_BASE_MID_IDX:     mid_d = wb;
        SYNTH_BASE_LOW_IDX:     lo_d = wb;
        BANDWIDTH_RATE_CFG_IDX: bw_d = wb;
        CHANNEL_INDEX_IDX:      channel_index_d = wb;
        SPACING_CFG_IDX:        spc_d = wb;
        SIGNIFICAND_CFG_IDX:    sig_d = wb;
        RADIO_CTRL_IDX: begin
          rx_d      = wb[RADIO_RX_BIT];
          auto_en_d = wb[RADIO_AUTO_BIT];
          strobe    = wb[RADIO_STROBE_BIT];
        end
        default: ;
      endcase
    end
    // correction update wins over a plain write in the same cycle
    if (strobe || (auto_en_q && auto_rise)) begin
      off_d = off_q + i_offset_estimate;
    end
  end

  // derived words
  always_comb begin
    base_word  = {hi_q, mid_q, lo_q};
    shift_word = {{14{off_q[7]}}, off_q, 2'b00};
    channel_index_word  = {16'h0000, channel_index_q} * {16'h0000, spc_q};
    tuned_word = base_word + shift_word + channel_index_word;
    if_word    = {13'h0000, if_q[4:0], 6'h00};
    bw_div     = MANT_BIAS + {2'b00, bw_q[FW_MANT_LSB +: 2]};
    cfg_d                = cfg_q;
    cfg_d.synth_word     = tuned_word;
    cfg_d.rx_word        = rx_q ? tuned_word - if_word : tuned_word;
    cfg_d.rate_word      = {15'h0000, HIDDEN_ONE | {1'b0, sig_q}}
                           << bw_q[3:0];
    cfg_d.decim          = {4'h0, bw_div} << bw_q[FW_EXP_LSB +: 2];
    cfg_d.if_tuning_word = if_q[4:0];
  end

  // bus answer
  always_comb begin
    pready_d  = setup;
    pslverr_d = 1'b0;
    prdata_d  = 32'h0000_0000;
    if (setup) begin
      pslverr_d = ~hit;
      if (!i_pwrite) begin
        case (idx)
          IF_TUNING_CTRL_IDX:     prdata_d[7:0] = if_q;
          SYNTH_OFFSET_CTRL_IDX:  prdata_d[7:0] = off_q;
          SYNTH_BASE_HIGH_IDX:    prdata_d[7:0] = hi_q;
          SYNTH_BASE_MID_IDX:     prdata_d[7:0] = mid_q;
          SYNTH_BASE_LOW_IDX:     prdata_d[7:0] = lo_q;
          BANDWIDTH_RATE_CFG_IDX: prdata_d[7:0] = bw_q;
          CHANNEL_INDEX_IDX:      prdata_d[7:0] = channel_index_q;
          SPACING_CFG_IDX:        prdata_d[7:0] = spc_q;
          SIGNIFICAND_CFG_IDX:    prdata_d[7:0] = sig_q;
          RADIO_CTRL_IDX: begin
            prdata_d[RADIO_RX_BIT]   = rx_q;
            prdata_d[RADIO_AUTO_BIT] = auto_en_q;
          end
          SYNTH_WORD_RD_IDX:      prdata_d[23:0] = cfg_q.synth_word;
          RX_WORD_RD_IDX:         prdata_d[23:0] = cfg_q.rx_word;
          RATE_WORD_RD_IDX:       prdata_d[23:0] = cfg_q.rate_word;
          DECIM_RD_IDX:           prdata_d[7:0]  = cfg_q.decim;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      if_q      <= IF_TUNING_RST;
      off_q     <= SYNTH_OFFSET_RST;
      hi_q      <= SYNTH_HIGH_RST;
      mid_q     <= SYNTH_MID_RST;
      lo_q      <= SYNTH_LOW_RST;
      bw_q      <= BW_RATE_RST;
      channel_index_q    <= CHANNEL_RST;
      spc_q     <= SPACING_RST;
      sig_q     <= SIGNIFICAND_RST;
      rx_q      <= 1'b0;
      auto_en_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      cfg_q     <= '0;
    end else begin
      if_q      <= if_d;
      off_q     <= off_d;
      hi_q      <= hi_d;
      mid_q     <= mid_d;
      lo_q      <= lo_d;
      bw_q      <= bw_d;
      channel_index_q    <= channel_index_d;
      spc_q     <= spc_d;
      sig_q     <= sig_d;
      rx_q      <= rx_d;
      auto_en_q <= auto_en_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      cfg_q     <= cfg_d;
    end
  end

  assign o_prdata  = prdata_q;
  assign o_pready  = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_cfg     = cfg_q;

  property p_if_reserved;
    @(posedge i_ref_clk) disable iff (i_srst) if_q[7:5] == 3'h0;
  endproperty
  a_if_reserved: assert property (p_if_reserved)
    else $error("if register reserved bits set");

  property p_high_ro;
    @(posedge i_ref_clk) disable iff (i_srst) hi_q[7:6] == 2'h0;
  endproperty
  a_high_ro: assert property (p_high_ro)
    else $error("base word top bits not zero");

  property p_strobe_add;
    @(posedge i_ref_clk) disable iff (i_srst)
      strobe |=> off_q == $past(off_q) + $past(i_offset_estimate);
  endproperty
  a_strobe_add: assert property (p_strobe_add)
    else $error("estimate not added to offset");

  property p_synth_word;
    @(posedge i_ref_clk) disable iff (i_srst)
      !i_srst |=> cfg_q.synth_word == $past(tuned_word);
  endproperty
  a_synth_word: assert property (p_synth_word)
    else $error("synth word wrong");

  property p_rx_if;
    @(posedge i_ref_clk) disable iff (i_srst)
      rx_q && $stable(rx_q) |=> cfg_q.rx_word == $past(tuned_word) -
        {13'h0000, $past(if_q[4:0]), 6'h00};
  endproperty
  a_rx_if: assert property (p_rx_if)
    else $error("rx word lacks if subtraction");

  property p_decim;
    @(posedge i_ref_clk) disable iff (i_srst)
      !i_srst |=> cfg_q.decim ==
        ({4'h0, $past(bw_div)} << $past(bw_q[7:6]));
  endproperty
  a_decim: assert property (p_decim)
    else $error("decimation ratio wrong");

  property p_rate;
    @(posedge i_ref_clk) disable iff (i_srst)
      !i_srst |=> cfg_q.rate_word ==
        (({15'h0000, HIDDEN_ONE} | {16'h0000, $past(sig_q)})
         << $past(bw_q[3:0]));
  endproperty
  a_rate: assert property (p_rate)
    else $error("rate word wrong");

  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  property p_answer;
    @(posedge i_ref_clk) disable iff (i_srst) s_setup |=> o_pready;
  endproperty
  a_answer: assert property (p_answer)
    else $error("bus answer late");

endmodule // sfcfg_top

// ==== pkg/sfcfg_pkg.sv ====
package sfcfg_pkg;

  // register offsets; printed offsets are not multiples of four, so each is
  // an index and the byte address is four times the index
  localparam logic [15:0] IF_TUNING_CTRL_IDX     = 16'hDF07;
  localparam logic [15:0] SYNTH_OFFSET_CTRL_IDX  = 16'hDF08;
  localparam logic [15:0] SYNTH_BASE_HIGH_IDX    = 16'hDF09;
  localparam logic [15:0] SYNTH_BASE_MID_IDX     = 16'hDF0A;
  localparam logic [15:0] SYNTH_BASE_LOW_IDX     = 16'hDF0B;
  localparam logic [15:0] BANDWIDTH_RATE_CFG_IDX = 16'hDF0C;
  localparam logic [15:0] CHANNEL_INDEX_IDX      = 16'hDF06;
  localparam logic [15:0] SPACING_CFG_IDX        = 16'hE000;
  localparam logic [15:0] SIGNIFICAND_CFG_IDX    = 16'hE001;
  localparam logic [15:0] RADIO_CTRL_IDX         = 16'hE002;
  localparam logic [15:0] SYNTH_WORD_RD_IDX      = 16'hE003;
  localparam logic [15:0] RX_WORD_RD_IDX         = 16'hE004;
  localparam logic [15:0] RATE_WORD_RD_IDX       = 16'hE005;
  localparam logic [15:0] DECIM_RD_IDX           = 16'hE006;
  localparam int          IDX_LSB                = 2;

  // reset values
  localparam logic [7:0] IF_TUNING_RST     = 8'h0F;
  localparam logic [7:0] SYNTH_OFFSET_RST  = 8'h00;
  localparam logic [7:0] SYNTH_HIGH_RST    = 8'h1E;
  localparam logic [7:0] SYNTH_MID_RST     = 8'hC4;
  localparam logic [7:0] SYNTH_LOW_RST     = 8'hEC;
  localparam logic [7:0] BW_RATE_RST       = 8'h8C;
  localparam logic [7:0] CHANNEL_RST       = 8'h00;
  localparam logic [7:0] SPACING_RST       = 8'h01;
  localparam logic [7:0] SIGNIFICAND_RST   = 8'h22;

  // field layout
  localparam logic [7:0] IF_WORD_MASK      = 8'h1F;
  localparam logic [7:0] BASE_HIGH_MASK    = 8'h3F;
  localparam int         FW_EXP_LSB        = 6;
  localparam int         FW_MANT_LSB       = 4;
  localparam int         RADIO_RX_BIT      = 0;
  localparam int         RADIO_STROBE_BIT  = 1;
  localparam int         RADIO_AUTO_BIT    = 2;

  // word scaling: if word counts fxosc/2^10, base word fxosc/2^16
  localparam int         IF_TO_BASE_SHIFT  = 6;
  // offset counts fxosc/2^14
  localparam int         OFF_TO_BASE_SHIFT = 2;
  localparam logic [3:0] MANT_BIAS         = 4'h4;
  localparam logic [8:0] HIDDEN_ONE        = 9'h100;

  typedef struct packed {
    logic [23:0] synth_word;
    logic [23:0] rx_word;
    logic [23:0] rate_word;
    logic [7:0]  decim;
    logic [4:0]  if_tuning_word;
  } sfcfg_out_t;

endpackage : sfcfg_pkg

// ==== hdl/sfcfg_sync.sv ====
module sfcfg_sync (
  input  wire logic i_ref_clk,
  input  wire logic i_srst,
  input  wire logic i_async,
  output logic      o_level,
  output logic      o_rise
);
  import sfcfg_pkg::*;

  logic [2:0] sh_q;
  logic [2:0] sh_d;
  logic       lvl_q;
  logic       lvl_d;
  logic       rise_q;
  logic       rise_d;

  // a change counts once the second and third stage agree
  always_comb begin
    sh_d   = {sh_q[1:0], i_async};
    lvl_d  = lvl_q;
    rise_d = 1'b0;
    if (sh_q[1] == sh_q[2]) begin
      lvl_d  = sh_q[2];
      rise_d = sh_q[2] & ~lvl_q;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      sh_q   <= 3'h0;
      lvl_q  <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      sh_q   <= sh_d;
      lvl_q  <= lvl_d;
      rise_q <= rise_d;
    end
  end

  assign o_level = lvl_q;
  assign o_rise  = rise_q;

endmodule // sfcfg_sync

// ==== testbench/sfcfg_top_tb.sv ====
module sfcfg_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sfcfg_pkg::*;

  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic [7:0]  estimate = 8'h00;
  logic        auto_corr = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  sfcfg_out_t  cfg;
  int          fails = 0;
  int          total_checks = 0;

  always #20 ref_clk = ~ref_clk;

  sfcfg_top i_sfcfg_top (
    .i_ref_clk        (ref_clk),
    .i_srst           (srst),
    .i_psel           (psel),
    .i_penable        (penable),
    .i_pwrite         (pwrite),
    .i_paddr          (paddr),
    .i_pwdata         (pwdata),
    .i_pstrb          (pstrb),
    .i_offset_estimate(estimate),
    .i_auto_correct   (auto_corr),
    .o_prdata         (prdata),
    .o_pready         (pready),
    .o_pslverr        (pslverr),
    .o_cfg            (cfg)
  );

  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [15:0] idx,
                     input logic [7:0] d, input logic [3:0] st,
                     output logic [31:0] rd, output logic err);
    int n = 0;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {14'h0, idx, 2'h0};
    pwdata  <= {24'h0, d};
    pstrb   <= st;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    chk("pready", 32'h1, {31'h0, pready});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, d, 4'hF, r, e);
  endtask

  task automatic rdc(input string nm, input logic [15:0] idx,
                     input logic [31:0] ex);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 8'h00, 4'h0, r, e);
    chk(nm, ex, r);
  endtask

  task automatic test_reset_values();
    rdc("if_ctrl", IF_TUNING_CTRL_IDX, 32'h0F);
    rdc("offset", SYNTH_OFFSET_CTRL_IDX, 32'h00);
    rdc("base_high", SYNTH_BASE_HIGH_IDX, 32'h1E);
    rdc("base_mid", SYNTH_BASE_MID_IDX, 32'hC4);
    rdc("base_low", SYNTH_BASE_LOW_IDX, 32'hEC);
    rdc("bw_rate", BANDWIDTH_RATE_CFG_IDX, 32'h8C);
    chk("synth_word", 32'h1EC4EC, {8'h0, cfg.synth_word});
    chk("rate_word", 32'h122000, {8'h0, cfg.rate_word});
    chk("decim", 32'h10, {24'h0, cfg.decim});
    chk("if_word", 32'h0F, {27'h0, cfg.if_tuning_word});
    $display("test reset values done");
  endtask

  task automatic test_masks();
    logic [31:0] r;
    logic        e;
    wr(IF_TUNING_CTRL_IDX, 8'hFF);
    rdc("if_ctrl", IF_TUNING_CTRL_IDX, 32'h1F);
    wr(SYNTH_BASE_HIGH_IDX, 8'hFF);
    rdc("base_high", SYNTH_BASE_HIGH_IDX, 32'h3F);
    // lane 0 strobe low must leave the register alone
    apb(1'b1, IF_TUNING_CTRL_IDX, 8'h03, 4'hE, r, e);
    rdc("if_ctrl", IF_TUNING_CTRL_IDX, 32'h1F);
    apb(1'b0, 16'hDF00, 8'h00, 4'h0, r, e);
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0, r);
    $display("test masks done");
  endtask

  task automatic test_frequency();
    wr(SYNTH_BASE_HIGH_IDX, 8'h10);
    wr(SYNTH_BASE_MID_IDX, 8'h00);
    wr(SYNTH_BASE_LOW_IDX, 8'h00);
    wr(IF_TUNING_CTRL_IDX, 8'h0F);
    wr(SYNTH_OFFSET_CTRL_IDX, 8'hFE);
    wr(CHANNEL_INDEX_IDX, 8'h03);
    wr(SPACING_CFG_IDX, 8'h05);
    wr(RADIO_CTRL_IDX, 8'h01);
    repeat (3) @(posedge ref_clk);
    chk("synth_word", 32'h100007, {8'h0, cfg.synth_word});
    chk("rx_word", 32'h0FFC47, {8'h0, cfg.rx_word});
    rdc("synth_rd", SYNTH_WORD_RD_IDX, 32'h100007);
    rdc("rx_rd", RX_WORD_RD_IDX, 32'h0FFC47);
    $display("test frequency done");
  endtask

  task automatic test_correction();
    estimate <= 8'h05;
    wr(RADIO_CTRL_IDX, 8'h03);
    rdc("offset_strobe", SYNTH_OFFSET_CTRL_IDX, 32'h03);
    wr(RADIO_CTRL_IDX, 8'h05);
    @(posedge ref_clk);
    auto_corr <= 1'b1;
    repeat (5) @(posedge ref_clk);
    auto_corr <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rdc("offset_auto", SYNTH_OFFSET_CTRL_IDX, 32'h08);
    rdc("synth_rd", SYNTH_WORD_RD_IDX, 32'h10002F);
    $display("test correction done");
  endtask

  task automatic test_bandwidth();
    // exponent 3, mantissa 1, rate exponent 5; never both zero
    wr(BANDWIDTH_RATE_CFG_IDX, 8'hD5);
    rdc("bw_rate", BANDWIDTH_RATE_CFG_IDX, 32'hD5);
    rdc("decim_rd", DECIM_RD_IDX, 32'h28);
    rdc("rate_rd", RATE_WORD_RD_IDX, 32'h2440);
    chk("decim", 32'h28, {24'h0, cfg.decim});
    $display("test bandwidth done");
  endtask

  // reset in mid-run must bring back the defaults
  task automatic test_mid_reset();
    wr(SYNTH_BASE_MID_IDX, 8'h55);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rdc("base_mid_rst", SYNTH_BASE_MID_IDX, 32'hC4);
    rdc("offset_rst", SYNTH_OFFSET_CTRL_IDX, 32'h00);
    rdc("bw_rate_rst", BANDWIDTH_RATE_CFG_IDX, 32'h8C);
    chk("rx_word_rst", 32'h1EC4EC, {8'h0, cfg.rx_word});
    $display("test mid reset done");
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    test_reset_values();
    test_masks();
    test_frequency();
    test_correction();
    test_bandwidth();
    test_mid_reset();
    test_done();
  end

  initial begin
    repeat (3000) @(posedge ref_clk);
    fails++;
    test_done();
  end
endmodule // sfcfg_top_tb
